/* File: shared/qfc_regs.svh */
`ifndef QFC_REGS_SVH
`define QFC_REGS_SVH

// Control word 0 fields
`define QFC_C0_PROT_LSB 1
`define QFC_C0_PROT_MSB 3
`define QFC_C0_RW_BIT 4
`define QFC_C0_CMD_BIT 5
`define QFC_C0_ADDR_LSB 6
`define QFC_C0_ADDR_MSB 7
`define QFC_C0_CFG_LSB 8
`define QFC_C0_CFG_MSB 11
`define QFC_C0_DMY_LSB 12
`define QFC_C0_DMY_MSB 15
`define QFC_C0_DATA_LSB 16
`define QFC_C0_DATA_MSB 24

// Control word 1 fields
`define QFC_C1_PINS_BIT 16
`define QFC_C1_OUT0_BIT 17
`define QFC_C1_OUT1_BIT 18

// Instruction word fields
`define QFC_I0_ADDR_LSB 0
`define QFC_I0_ADDR_MSB 23
`define QFC_I0_CMD_LSB 24
`define QFC_I0_CMD_MSB 31
`define QFC_I1_CFG_LSB 0
`define QFC_I1_CFG_MSB 7

// Encodings
`define QFC_PROT_INVALID 3'h0
`define QFC_CFG_MAX 4'h8
`define QFC_W1 2'h0
`define QFC_W2 2'h1
`define QFC_W4 2'h2

// Timing: serial clock half period in reference clock cycles; receive FIFO depth in bytes
`define QFC_SCK_HALF 3
`define QFC_FIFO_DEPTH 4

`endif

/* File: shared/qfc_pkg.sv */
`default_nettype none

package qfc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_CFG,
        ST_DUMMY,
        ST_DATA
    } qfc_state_type;

    typedef struct packed {
        logic [2:0] prot;
        logic wr;
        logic cmd_en;
        logic [1:0] addr_len;
        logic [3:0] cfg_len;
        logic [3:0] dmy_len;
        logic [8:0] data_len;
        logic pins_direct;
        logic out0;
        logic out1;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] cfg;
    } qfc_desc_type;

    typedef struct packed {
        logic [1:0] cmd_w;
        logic [1:0] addr_w;
        logic [1:0] cfg_w;
        logic [1:0] data_w;
        logic dmy_hiz;
    } qfc_lanes_type;

endpackage

`default_nettype wire

/* File: design/qfc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module qfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
            $error("qfc_fifo: depth below two or zero width");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_ready = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_inc;
            if (pop)
                rd_ptr <= rd_inc;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

endmodule

`default_nettype wire

/* File: design/qfc_seq.sv */
`timescale 1ns/100ps
`default_nettype none
`include "qfc_regs.svh"

module qfc_seq #(
    parameter int SCK_HALF = `QFC_SCK_HALF,
    parameter int FIFO_DEPTH = `QFC_FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [31:0] CTRL0,
    input wire logic [31:0] CTRL1,
    input wire logic [31:0] INSTR0,
    input wire logic [31:0] INSTR1,
    input wire logic WR_VALID,
    output logic WR_READY,
    input wire logic [7:0] WR_DATA,
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [7:0] RD_DATA,
    output logic BUSY,
    output logic DONE,
    output logic PROT_ERR,
    input wire logic SOFT_RESET_REQ,
    input wire logic BOOT_FLASH_CMD,
    output logic BOOT_HOST_MODE,
    output logic FLASH_SCK,
    output logic FLASH_CS_N,
    output logic [3:0] FLASH_IO_OUT,
    output logic [3:0] FLASH_IO_OE,
    input wire logic [3:0] FLASH_IO_IN
);
    localparam int CW = $clog2(2 * SCK_HALF);

    initial
    begin
        if (SCK_HALF < 3)
            $error("qfc_seq: serial clock half period must be at least three cycles");
    end

    qfc_pkg::qfc_state_type state;
    qfc_pkg::qfc_state_type next_state;
    qfc_pkg::qfc_desc_type desc;
    qfc_pkg::qfc_desc_type in_desc;
    qfc_pkg::qfc_lanes_type lanes;
    qfc_pkg::qfc_lanes_type in_lanes;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [23:0] sh;
    logic [4:0] clk_left;
    logic [8:0] bytes_left;
    logic [7:0] rx;
    logic need_byte;
    logic push_q;
    logic [7:0] push_data;
    logic [3:0] io_meta;
    logic [3:0] io_sync;
    logic [3:0] next_io_out;
    logic [3:0] next_io_oe;
    logic fifo_in_ready;

    function automatic qfc_pkg::qfc_lanes_type lanes_of(input logic [2:0] p);
        case (p)
            3'h1: lanes_of = {`QFC_W1, `QFC_W1, `QFC_W1, `QFC_W1, 1'b0};
            3'h2: lanes_of = {`QFC_W1, `QFC_W1, `QFC_W1, `QFC_W2, 1'b1};
            3'h3: lanes_of = {`QFC_W1, `QFC_W1, `QFC_W1, `QFC_W4, 1'b1};
            3'h4: lanes_of = {`QFC_W1, `QFC_W2, `QFC_W2, `QFC_W2, 1'b1};
            3'h5: lanes_of = {`QFC_W1, `QFC_W4, `QFC_W4, `QFC_W4, 1'b1};
            3'h6: lanes_of = {`QFC_W2, `QFC_W2, `QFC_W2, `QFC_W2, 1'b1};
            3'h7: lanes_of = {`QFC_W4, `QFC_W4, `QFC_W4, `QFC_W4, 1'b1};
            default: lanes_of = {`QFC_W1, `QFC_W1, `QFC_W1, `QFC_W1, 1'b0};
        endcase
    endfunction

    function automatic logic [1:0] lane_of(input qfc_pkg::qfc_state_type s,
                                           input qfc_pkg::qfc_lanes_type l);
        case (s)
            qfc_pkg::ST_CMD: lane_of = l.cmd_w;
            qfc_pkg::ST_ADDR: lane_of = l.addr_w;
            qfc_pkg::ST_CFG: lane_of = l.cfg_w;
            qfc_pkg::ST_DUMMY: lane_of = l.data_w;
            qfc_pkg::ST_DATA: lane_of = l.data_w;
            default: lane_of = `QFC_W1;
        endcase
    endfunction

    function automatic qfc_pkg::qfc_state_type next_phase(input qfc_pkg::qfc_state_type f,
                                                          input qfc_pkg::qfc_desc_type d);
        if (f == qfc_pkg::ST_IDLE && d.cmd_en)
            next_phase = qfc_pkg::ST_CMD;
        else if (f <= qfc_pkg::ST_CMD && d.addr_len != 2'h0)
            next_phase = qfc_pkg::ST_ADDR;
        else if (f <= qfc_pkg::ST_ADDR && d.cfg_len != 4'h0)
            next_phase = qfc_pkg::ST_CFG;
        else if (f <= qfc_pkg::ST_CFG && d.dmy_len != 4'h0)
            next_phase = qfc_pkg::ST_DUMMY;
        else if (f <= qfc_pkg::ST_DUMMY && d.data_len != 9'h0)
            next_phase = qfc_pkg::ST_DATA;
        else
            next_phase = qfc_pkg::ST_IDLE;
    endfunction

    function automatic logic [4:0] phase_clocks(input qfc_pkg::qfc_state_type s,
                                                input qfc_pkg::qfc_desc_type d,
                                                input qfc_pkg::qfc_lanes_type l);
        logic [1:0] w;
        logic [4:0] c;
        w = lane_of(s, l);
        c = (d.cfg_len > `QFC_CFG_MAX) ? {1'b0, `QFC_CFG_MAX} : {1'b0, d.cfg_len};
        case (s)
            qfc_pkg::ST_CMD: phase_clocks = 5'h8 >> w;
            qfc_pkg::ST_ADDR: phase_clocks = {d.addr_len, 3'h0} >> w;
            qfc_pkg::ST_CFG: phase_clocks = (c + ((5'h1 << w) - 5'h1)) >> w;
            qfc_pkg::ST_DUMMY: phase_clocks = {1'b0, d.dmy_len};
            qfc_pkg::ST_DATA: phase_clocks = 5'h8 >> w;
            default: phase_clocks = 5'h0;
        endcase
    endfunction

    function automatic logic [23:0] phase_bits(input qfc_pkg::qfc_state_type s,
                                               input qfc_pkg::qfc_desc_type d);
        case (s)
            qfc_pkg::ST_CMD: phase_bits = {d.cmd, 16'h0000};
            qfc_pkg::ST_ADDR:
                case (d.addr_len)
                    2'h1: phase_bits = {d.addr[7:0], 16'h0000};
                    2'h2: phase_bits = {d.addr[15:0], 8'h00};
                    default: phase_bits = d.addr;
                endcase
            qfc_pkg::ST_CFG: phase_bits = {d.cfg, 16'h0000};
            default: phase_bits = 24'h000000;
        endcase
    endfunction

    assign in_desc.prot = CTRL0[`QFC_C0_PROT_MSB:`QFC_C0_PROT_LSB];
    assign in_desc.wr = CTRL0[`QFC_C0_RW_BIT];
    assign in_desc.cmd_en = CTRL0[`QFC_C0_CMD_BIT];
    assign in_desc.addr_len = CTRL0[`QFC_C0_ADDR_MSB:`QFC_C0_ADDR_LSB];
    assign in_desc.cfg_len = CTRL0[`QFC_C0_CFG_MSB:`QFC_C0_CFG_LSB];
    assign in_desc.dmy_len = CTRL0[`QFC_C0_DMY_MSB:`QFC_C0_DMY_LSB];
    assign in_desc.data_len = CTRL0[`QFC_C0_DATA_MSB:`QFC_C0_DATA_LSB];
    assign in_desc.pins_direct = CTRL1[`QFC_C1_PINS_BIT];
    assign in_desc.out0 = CTRL1[`QFC_C1_OUT0_BIT];
    assign in_desc.out1 = CTRL1[`QFC_C1_OUT1_BIT];
    assign in_desc.addr = INSTR0[`QFC_I0_ADDR_MSB:`QFC_I0_ADDR_LSB];
    assign in_desc.cmd = INSTR0[`QFC_I0_CMD_MSB:`QFC_I0_CMD_LSB];
    assign in_desc.cfg = INSTR1[`QFC_I1_CFG_MSB:`QFC_I1_CFG_LSB];

    assign lanes = lanes_of(desc.prot);
    assign in_lanes = lanes_of(in_desc.prot);

    wire is_idle = (state == qfc_pkg::ST_IDLE);
    wire in_data = (state == qfc_pkg::ST_DATA);
    wire running = !is_idle && !(in_data && need_byte);
    wire bit_end = running && (cnt == CW'(2 * SCK_HALF - 1));
    wire phase_last = bit_end && (clk_left == 5'h1);
    wire data_more = in_data && (bytes_left > 9'h001);
    wire [1:0] cur_w = lane_of(state, lanes);
    wire quad_prot = (lanes.data_w == `QFC_W4) || (lanes.addr_w == `QFC_W4);
    wire take = CMD_VALID && CMD_READY;
    wire bad_prot = take && (in_desc.prot == `QFC_PROT_INVALID);
    wire take_ok = take && !bad_prot;
    wire rd_grant = in_data && need_byte && !desc.wr && fifo_in_ready && !push_q;
    wire wr_grant = WR_READY && WR_VALID;
    wire [23:0] sh_next = (cur_w == `QFC_W4) ? {sh[19:0], 4'h0} :
                          (cur_w == `QFC_W2) ? {sh[21:0], 2'h0} : {sh[22:0], 1'b0};
    wire [7:0] rx_next = (cur_w == `QFC_W4) ? {rx[3:0], io_sync} :
                         (cur_w == `QFC_W2) ? {rx[5:0], io_sync[1:0]} : {rx[6:0], io_sync[1]};
    wire enter = take_ok || (phase_last && !data_more);
    wire qfc_pkg::qfc_desc_type src_desc = take_ok ? in_desc : desc;
    wire qfc_pkg::qfc_lanes_type src_lanes = take_ok ? in_lanes : lanes;

    assign CMD_READY = is_idle;
    assign WR_READY = in_data && need_byte && desc.wr;
    assign BUSY = !is_idle;

    assign next_state = SOFT_RESET_REQ ? qfc_pkg::ST_IDLE :
                        take_ok ? next_phase(qfc_pkg::ST_IDLE, in_desc) :
                        (phase_last && !data_more) ? next_phase(state, desc) : state;
    assign next_cnt = (!running || bit_end) ? '0 : cnt + 1'b1;

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            state <= qfc_pkg::ST_IDLE;
            desc <= '0;
            cnt <= '0;
            FLASH_SCK <= 1'b0;
            FLASH_CS_N <= 1'b1;
            DONE <= 1'b0;
            PROT_ERR <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (take_ok)
                desc <= in_desc;
            cnt <= (next_state == qfc_pkg::ST_IDLE) ? '0 : next_cnt;
            FLASH_SCK <= (next_state != qfc_pkg::ST_IDLE) && (next_cnt >= CW'(SCK_HALF));
            FLASH_CS_N <= (next_state == qfc_pkg::ST_IDLE);
            DONE <= !SOFT_RESET_REQ && (next_state == qfc_pkg::ST_IDLE) && (take_ok || !is_idle);
            PROT_ERR <= bad_prot;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            sh <= '0;
            clk_left <= '0;
            bytes_left <= '0;
            need_byte <= 1'b0;
        end
        else if (enter)
        begin
            sh <= phase_bits(next_state, src_desc);
            clk_left <= phase_clocks(next_state, src_desc, src_lanes);
            need_byte <= (next_state == qfc_pkg::ST_DATA);
            if (take_ok)
                bytes_left <= in_desc.data_len;
        end
        else if (wr_grant || rd_grant)
        begin
            sh <= {WR_DATA, 16'h0000};
            need_byte <= 1'b0;
        end
        else if (bit_end)
        begin
            sh <= sh_next;
            clk_left <= phase_last ? phase_clocks(state, desc, lanes) : clk_left - 5'h1;
            if (phase_last)
            begin
                bytes_left <= bytes_left - 9'h001;
                need_byte <= 1'b1;
            end
        end
    end

    // Received byte is pushed one cycle after its last clock
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            rx <= '0;
            push_q <= 1'b0;
            push_data <= '0;
        end
        else
        begin
            if (bit_end)
                rx <= rx_next;
            push_q <= phase_last && in_data && !desc.wr && !SOFT_RESET_REQ;
            if (phase_last)
                push_data <= rx_next;
        end
    end

    // Pin inputs pass two flops before use
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            io_meta <= '0;
            io_sync <= '0;
        end
        else
        begin
            io_meta <= FLASH_IO_IN;
            io_sync <= io_meta;
        end
    end

    always_comb
    begin
        next_io_out = 4'h0;
        next_io_oe = 4'h0;
        if (state == qfc_pkg::ST_CMD || state == qfc_pkg::ST_ADDR ||
            state == qfc_pkg::ST_CFG || (in_data && desc.wr))
        begin
            case (cur_w)
                `QFC_W4:
                begin
                    next_io_out = sh[23:20];
                    next_io_oe = 4'hF;
                end
                `QFC_W2:
                begin
                    next_io_out = {2'h0, sh[23:22]};
                    next_io_oe = 4'h3;
                end
                default:
                begin
                    next_io_out = {3'h0, sh[23]};
                    next_io_oe = 4'h1;
                end
            endcase
        end
        else if (state == qfc_pkg::ST_DUMMY && !lanes.dmy_hiz)
            next_io_oe = 4'h1;
        if (desc.pins_direct)
        begin
            next_io_out[3:2] = {desc.out1, desc.out0};
            next_io_oe[3:2] = 2'h3;
        end
        // upper lines join bus or stay high
        else if (!(quad_prot && !is_idle && cur_w == `QFC_W4))
        begin
            next_io_out[3:2] = 2'h3;
            next_io_oe[3:2] = 2'h3;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            FLASH_IO_OUT <= 4'hC;
            FLASH_IO_OE <= 4'hC;
        end
        else
        begin
            FLASH_IO_OUT <= next_io_out;
            FLASH_IO_OE <= next_io_oe;
        end
    end

    // boot mode flag, set wins over clear
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            BOOT_HOST_MODE <= 1'b0;
        else if (SOFT_RESET_REQ)
            BOOT_HOST_MODE <= 1'b1;
        else if (BOOT_FLASH_CMD)
            BOOT_HOST_MODE <= 1'b0;
    end

    qfc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA)
    );

    sequence seq_bad_take;
        CMD_VALID && CMD_READY && in_desc.prot == `QFC_PROT_INVALID;
    endsequence

    sequence seq_soft_reset;
        state == qfc_pkg::ST_IDLE && FLASH_CS_N && BOOT_HOST_MODE && !DONE;
    endsequence

    chk_upper_direct: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        desc.pins_direct |=> FLASH_IO_OE[3:2] == 2'h3 &&
            FLASH_IO_OUT[3:2] == {$past(desc.out1), $past(desc.out0)})
        else $error("upper lines not following direct bits");
    chk_upper_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !desc.pins_direct && !quad_prot |=> FLASH_IO_OUT[3:2] == 2'h3 && FLASH_IO_OE[3:2] == 2'h3)
        else $error("upper lines not held high");
    chk_quad_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !desc.pins_direct && in_data && !desc.wr && cur_w == `QFC_W4 |=> FLASH_IO_OE == 4'h0)
        else $error("quad read still driving lines");
    chk_phase_order: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        state != qfc_pkg::ST_IDLE && $past(state) != qfc_pkg::ST_IDLE && state != $past(state)
            |-> state > $past(state))
        else $error("phase order broken");
    chk_prot2_dummy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        desc.prot == 3'h2 && state == qfc_pkg::ST_DUMMY && !desc.pins_direct
            |=> FLASH_IO_OE[1:0] == 2'h0)
        else $error("protocol 2 dummy driven");
    chk_prot5_lanes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        desc.prot == 3'h5 && state == qfc_pkg::ST_CMD |=> FLASH_IO_OE[1:0] == 2'h1)
        else $error("protocol 5 command not single line");
    chk_prot6_addr: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        desc.prot == 3'h6 && state == qfc_pkg::ST_ADDR |=> FLASH_IO_OE[1:0] == 2'h3)
        else $error("protocol 6 address not dual");
    chk_bad_prot: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        seq_bad_take |=> PROT_ERR && state == qfc_pkg::ST_IDLE && FLASH_CS_N)
        else $error("invalid protocol accepted");
    chk_dummy_len: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(state == qfc_pkg::ST_DUMMY) |-> clk_left == {1'b0, desc.dmy_len})
        else $error("dummy length wrong");
    chk_boot_host: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        SOFT_RESET_REQ |=> seq_soft_reset)
        else $error("soft reset did not select host boot");

endmodule

`default_nettype wire

/* File: dv/qfc_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none

module qfc_flash_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    output logic [3:0] io_in,
    output logic [47:0] cap,
    output int n_clk
);
    logic half = 1'b0;
    logic [3:0] pat;
    // Read pattern alternates per clock; inverted while not selected
    assign pat = half ? 4'h5 : 4'hA;
    assign io_in = (io_oe & io_out) | (~io_oe & (cs_n ? ~pat : pat));
    initial cap = '0;
    initial n_clk = 0;
    always @(negedge cs_n)
    begin
        half = 1'b0;
        n_clk = 0;
    end
    // Flash samples line 0 on each rising clock
    always @(posedge sck)
    begin
        if (!cs_n)
        begin
            n_clk++;
            cap = {cap[46:0], io_in[0]};
        end
    end
    always @(negedge sck)
    begin
        if (!cs_n)
            half = ~half;
    end
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end

module tb_top;
    logic REF_CLK = 1'b0, SYS_RST = 1'b1, CMD_VALID = 1'b0, WR_VALID = 1'b1, RD_READY = 1'b1;
    logic SOFT_RESET_REQ = 1'b0, BOOT_FLASH_CMD = 1'b0;
    logic [31:0] CTRL0 = '0, CTRL1 = '0, INSTR0 = '0, INSTR1 = '0;
    logic [7:0] WR_DATA = 8'h3C;
    logic CMD_READY, WR_READY, RD_VALID, BUSY, DONE, PROT_ERR, BOOT_HOST_MODE;
    logic FLASH_SCK, FLASH_CS_N;
    logic [7:0] RD_DATA;
    logic [3:0] FLASH_IO_OUT, FLASH_IO_OE, FLASH_IO_IN, oe_s, out_s;
    logic [47:0] cap;
    int n_clk;
    int n_fail = 0;
    int n_tests = 0;
    int n_wr = 0;
    logic [7:0] rdq[$];
    logic [7:0] exp_rd[1:7] = '{8'hAA, 8'h99, 8'hA5, 8'h99, 8'hA5, 8'h99, 8'hA5};

    always #20 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK)
    begin
        if (RD_VALID && RD_READY)
            rdq.push_back(RD_DATA);
        if (WR_VALID && WR_READY)
            n_wr++;
    end

    qfc_seq qfc_seq_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
        .CMD_READY(CMD_READY), .CTRL0(CTRL0), .CTRL1(CTRL1), .INSTR0(INSTR0), .INSTR1(INSTR1),
        .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA), .RD_VALID(RD_VALID),
        .RD_READY(RD_READY), .RD_DATA(RD_DATA), .BUSY(BUSY), .DONE(DONE), .PROT_ERR(PROT_ERR),
        .SOFT_RESET_REQ(SOFT_RESET_REQ), .BOOT_FLASH_CMD(BOOT_FLASH_CMD),
        .BOOT_HOST_MODE(BOOT_HOST_MODE), .FLASH_SCK(FLASH_SCK), .FLASH_CS_N(FLASH_CS_N),
        .FLASH_IO_OUT(FLASH_IO_OUT), .FLASH_IO_OE(FLASH_IO_OE), .FLASH_IO_IN(FLASH_IO_IN));

    qfc_flash_model qfc_flash_model_i (.sck(FLASH_SCK), .cs_n(FLASH_CS_N), .io_out(FLASH_IO_OUT),
        .io_oe(FLASH_IO_OE), .io_in(FLASH_IO_IN), .cap(cap), .n_clk(n_clk));

    function automatic logic [31:0] c0(input logic [2:0] p, input logic rw, input logic ce,
        input logic [1:0] al, input logic [3:0] cl, input logic [3:0] dl, input logic [8:0] n);
        return {1'b1, 6'h00, n, dl, cl, al, ce, rw, p, 1'b1};
    endfunction

    task automatic results;
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic send(input logic [31:0] a, b, c, d);
        @(posedge REF_CLK);
        #1;
        {CTRL0, CTRL1, INSTR0, INSTR1} = {a, b, c, d};
        CMD_VALID = 1'b1;
        @(posedge REF_CLK);
        #1;
        CMD_VALID = 1'b0;
    endtask

    // Issue, probe the pins early in the frame, then wait for completion
    task automatic run(input logic [31:0] a, b, c, d);
        int i;
        rdq.delete();
        send(a, b, c, d);
        repeat (6) @(posedge REF_CLK);
        #1;
        oe_s = FLASH_IO_OE;
        out_s = FLASH_IO_OUT;
        i = 0;
        while (DONE !== 1'b1 && i < 3000)
        begin
            @(posedge REF_CLK);
            #1;
            i++;
        end
        if (i == 3000)
        begin
            n_fail++;
            results();
        end
        repeat (3) @(posedge REF_CLK);
        #1;
    endtask

    task automatic t_frame;
        run(c0(3'h1, 1'b0, 1'b1, 2'h3, 4'h8, 4'h0, 9'h000), 32'hFFF8_0000, 32'h9F12_3456,
            32'hFFFF_FF5A);
        `CHK(cap[39:0], 40'h9F_1234_565A)
        `CHK(n_clk, 40)
    endtask

    task automatic t_dummy;
        for (int d = 1; d <= 15; d += 14)
        begin
            run(c0(3'h2, 1'b0, 1'b1, 2'h0, 4'h0, 4'(d), 9'h000), '0, 32'hC300_0000, '0);
            `CHK(n_clk, 8 + d)
        end
    endtask

    task automatic t_read_all;
        logic q;
        for (int p = 1; p <= 7; p++)
        begin
            q = (p == 3 || p == 5 || p == 7);
            run(c0(3'(p), 1'b0, 1'b0, 2'h0, 4'h0, 4'h0, 9'h001), 32'h0006_0000, '0, '0);
            `CHK(rdq[0], exp_rd[p])
            `CHK(oe_s[3:2], q ? 2'b00 : 2'b11)
            `CHK(q ? 2'b11 : out_s[3:2], 2'b11)
        end
    endtask

    task automatic t_direct;
        for (int v = 1; v <= 2; v++)
        begin
            run(c0(3'h7, 1'b0, 1'b0, 2'h0, 4'h0, 4'h0, 9'h001), {13'h0, 2'(v), 1'b1, 16'h0},
                '0, '0);
            `CHK(oe_s[3:2], 2'b11)
            `CHK(out_s[3:2], 2'(v))
        end
    endtask

    // Command then one address byte; clock counts follow the lane widths
    task automatic t_lanes;
        run(c0(3'h5, 1'b0, 1'b1, 2'h1, 4'h0, 4'h0, 9'h000), '0, 32'hA500_005A, '0);
        `CHK(n_clk, 10)
        `CHK({oe_s, cap[9:0]}, {4'hD, 10'h296})
        run(c0(3'h6, 1'b0, 1'b1, 2'h1, 4'h0, 4'h0, 9'h000), '0, 32'hA500_005A, '0);
        `CHK(n_clk, 8)
        `CHK({oe_s, cap[7:0]}, {4'hF, 8'h3C})
    endtask

    task automatic t_prot_err;
        logic e;
        send(c0(3'h0, 1'b0, 1'b1, 2'h0, 4'h0, 4'h0, 9'h000), '0, 32'h0500_0000, '0);
        e = PROT_ERR;
        @(posedge REF_CLK);
        #1;
        e |= PROT_ERR;
        `CHK({e, FLASH_CS_N}, 2'b11)
        repeat (2) @(posedge REF_CLK);
    endtask

    task automatic t_recover;
        send(c0(3'h1, 1'b0, 1'b1, 2'h0, 4'h0, 4'h0, 9'h004), '0, 32'h0300_0000, '0);
        repeat (10) @(posedge REF_CLK);
        #1;
        SOFT_RESET_REQ = 1'b1;
        @(posedge REF_CLK);
        #1;
        SOFT_RESET_REQ = 1'b0;
        `CHK({FLASH_CS_N, BUSY, BOOT_HOST_MODE}, 3'b101)
        run(c0(3'h1, 1'b1, 1'b1, 2'h0, 4'h0, 4'h0, 9'h001), '0, 32'h0200_0000, '0);
        `CHK({cap[15:0], BOOT_HOST_MODE}, {16'h023C, 1'b1})
        `CHK(n_wr, 1)
        // boot from flash requested by command
        BOOT_FLASH_CMD = 1'b1;
        @(posedge REF_CLK);
        #1;
        BOOT_FLASH_CMD = 1'b0;
        `CHK(BOOT_HOST_MODE, 1'b0)
    endtask

    initial
    begin
        repeat (8) @(posedge REF_CLK);
        #1;
        SYS_RST = 1'b0;
        `CHK({CMD_READY, FLASH_CS_N, BUSY, FLASH_IO_OE, FLASH_IO_OUT}, 11'h6CC)
        t_frame();
        t_dummy();
        t_read_all();
        t_direct();
        t_lanes();
        t_prot_err();
        t_recover();
        results();
    end
endmodule

`default_nettype wire
